// *** meter_cfg_pkg.sv ***
// Register map, field layout and code definitions of the meter configuration
`default_nettype none
package meter_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices and widths
  // ----------------------------------------------------------------
  localparam int          REG_WIDTH             = 24;
  localparam int          ADDR_WIDTH            = 6;
  localparam logic [5:0]  MEASUREMENT_CONFIG_IDX = 6'h00;
  localparam logic [5:0]  OUTPUT_PIN_CONFIG_IDX  = 6'h01;
  localparam logic [5:0]  PHASE_COMPENSATION_IDX = 6'h05;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [23:0] MEASUREMENT_CONFIG_RESET = 24'h000200;
  localparam logic [23:0] OUTPUT_PIN_CONFIG_RESET  = 24'h00EEEE;
  localparam logic [23:0] PHASE_COMPENSATION_RESET = 24'h000000;
  localparam logic [23:0] MEASUREMENT_CONFIG_MASK  = 24'hFE5FFF;
  localparam logic [23:0] OUTPUT_PIN_CONFIG_MASK   = 24'h770FFF;
  localparam logic [23:0] OUTPUT_PIN_CONFIG_FIXED  = 24'h00E000;
  localparam logic [23:0] PHASE_COMPENSATION_MASK  = 24'hF3FFFF;

  // ----------------------------------------------------------------
  // Output pin configuration fields
  // ----------------------------------------------------------------
  localparam int PULSE_GEN_ENABLE_LSB = 20;
  localparam int OPEN_DRAIN_LSB       = 16;
  localparam int SOURCE_SELECT_WIDTH  = 4;

  // ----------------------------------------------------------------
  // Measurement configuration fields
  // ----------------------------------------------------------------
  localparam int FIXED_VOLTAGE_BIT    = 23;
  localparam int POSITIVE_ONLY_BIT    = 22;
  localparam int CHANNEL_CHOICE_BIT   = 21;
  localparam int HOLD_CHOICE_BIT      = 20;
  localparam int COMPARE_RMS_BIT      = 19;
  localparam int METER_CONFIG_LSB     = 17;
  localparam int APPARENT_METHOD_BIT  = 14;
  localparam int ZX_LOWPASS_BIT       = 12;
  localparam int AVERAGING_BASIS_BIT  = 11;
  localparam int CHECKSUM_DISABLE_BIT = 10;
  localparam int AUTO_FREQ_BIT        = 9;
  localparam int CURRENT2_FILTER_LSB  = 7;
  localparam int VOLTAGE2_FILTER_LSB  = 5;
  localparam int CURRENT1_FILTER_LSB  = 3;
  localparam int VOLTAGE1_FILTER_LSB  = 1;
  localparam int IIR_BYPASS_BIT       = 0;

  // ----------------------------------------------------------------
  // Phase compensation fields
  // ----------------------------------------------------------------
  localparam int COARSE_PAIR2_LSB  = 22;
  localparam int COARSE_PAIR1_LSB  = 20;
  localparam int FINE_PAIR2_LSB    = 9;
  localparam int FINE_PAIR1_LSB    = 0;
  localparam int FINE_PHASE_WIDTH  = 9;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_PULSE1     = 4'h0,
    SRC_PULSE2     = 4'h1,
    SRC_PULSE3     = 4'h2,
    SRC_P1_SIGN    = 4'h4,
    SRC_P2_SIGN    = 4'h5,
    SRC_PSUM_SIGN  = 4'h6,
    SRC_Q1_SIGN    = 4'h7,
    SRC_Q2_SIGN    = 4'h8,
    SRC_QSUM_SIGN  = 4'h9,
    SRC_VOLTAGE_ZX = 4'hB,
    SRC_CURRENT_ZX = 4'hC,
    SRC_HIGH_Z     = 4'hE,
    SRC_INTERRUPT  = 4'hF
  } source_type;

  typedef enum logic [1:0] {
    METER_ONE_CHANNEL = 2'h0,
    METER_HALF_SUM    = 2'h1
  } meter_type;

  typedef enum logic [1:0] {
    FILTER_NONE       = 2'h0,
    FILTER_HIGH_PASS  = 2'h1,
    FILTER_PHASE_MATCH = 2'h2,
    FILTER_INTEGRATOR = 2'h3
  } filter_type;

  typedef enum logic [1:0] {
    COARSE_NONE       = 2'h0,
    COARSE_CURRENT_1  = 2'h1,
    COARSE_VOLTAGE_1  = 2'h2,
    COARSE_VOLTAGE_2  = 2'h3
  } coarse_type;

endpackage : meter_cfg_pkg
`default_nettype wire

// *** meter_output_dsp_config.sv ***
// Configuration registers, output pin routing and engine option decode
`timescale 1ns/1ns
`default_nettype none

module meter_output_dsp_config #(
  parameter int POWER_WIDTH = 24
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic [meter_cfg_pkg::ADDR_WIDTH-1:0] reg_address,
  input  wire logic                                reg_write,
  input  wire logic [meter_cfg_pkg::REG_WIDTH-1:0]  reg_write_data,
  output logic      [meter_cfg_pkg::REG_WIDTH-1:0]  reg_read_data,
  input  wire logic [2:0]                          pulse_raw,
  input  wire logic [5:0]                          power_sign,
  input  wire logic                                voltage_zero_cross,
  input  wire logic                                current_zero_cross,
  input  wire logic                                interrupt_level,
  input  wire logic                                channel1_power_larger,
  input  wire logic                                channel1_current_larger,
  input  wire logic                                freq_measure_done,
  input  wire logic signed [POWER_WIDTH-1:0]        p1_avg_raw,
  input  wire logic signed [POWER_WIDTH-1:0]        p2_avg_raw,
  output logic      [2:0]                          pulse_gen_run,
  output logic      [2:0]                          pin_out,
  output logic      [2:0]                          pin_oe,
  output logic signed [POWER_WIDTH-1:0]             p1_avg,
  output logic signed [POWER_WIDTH-1:0]             p2_avg,
  output logic                                     use_voltage_reference,
  output logic                                     total_from_channel2,
  output logic                                     total_half_sum,
  output logic                                     apparent_root_sum,
  output logic                                     zero_cross_lowpass_en,
  output logic                                     average_by_cycles,
  output logic                                     checksum_enable,
  output logic                                     integrator_gain_load,
  output logic      [1:0]                          current1_filter_select,
  output logic      [1:0]                          current2_filter_select,
  output logic      [1:0]                          voltage1_filter_select,
  output logic      [1:0]                          voltage2_filter_select,
  output logic                                     iir_in_path,
  output logic      [1:0]                          current1_delay,
  output logic      [1:0]                          voltage1_delay,
  output logic      [1:0]                          current2_delay,
  output logic      [1:0]                          voltage2_delay,
  output logic      [8:0]                          fine_phase_pair1,
  output logic      [8:0]                          fine_phase_pair2
);
  import meter_cfg_pkg::*;

  if (POWER_WIDTH < 2) begin : g_width_check
    $error("POWER_WIDTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [23:0] measurement_config;
  logic [23:0] output_pin_config;
  logic [23:0] phase_compensation;

  wire hit_measurement = reg_address == MEASUREMENT_CONFIG_IDX;
  wire hit_output_pins = reg_address == OUTPUT_PIN_CONFIG_IDX;
  wire hit_phase       = reg_address == PHASE_COMPENSATION_IDX;

  // Reserved bits hold their fixed values whatever software writes
  wire [23:0] next_measurement_config =
    reg_write_data & MEASUREMENT_CONFIG_MASK;
  wire [23:0] next_output_pin_config =
    (reg_write_data & OUTPUT_PIN_CONFIG_MASK) | OUTPUT_PIN_CONFIG_FIXED;
  wire [23:0] next_phase_compensation =
    reg_write_data & PHASE_COMPENSATION_MASK;

  // Unmapped addresses read as zero
  wire [23:0] next_read_data =
    hit_measurement ? measurement_config :
    hit_output_pins ? output_pin_config :
    hit_phase       ? phase_compensation : 24'h000000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      measurement_config <= MEASUREMENT_CONFIG_RESET;
      output_pin_config  <= OUTPUT_PIN_CONFIG_RESET;
      phase_compensation <= PHASE_COMPENSATION_RESET;
      reg_read_data      <= 24'h000000;
    end else begin
      if (reg_write && hit_measurement)
        measurement_config <= next_measurement_config;
      if (reg_write && hit_output_pins)
        output_pin_config <= next_output_pin_config;
      if (reg_write && hit_phase)
        phase_compensation <= next_phase_compensation;
      reg_read_data <= next_read_data;
    end
  end

  // ----------------------------------------------------------------
  // Pulse generators and output pins
  // ----------------------------------------------------------------
  // Pulse generator gating
  wire [2:0] pulse_gen_enable =
    output_pin_config[PULSE_GEN_ENABLE_LSB +: 3];
  wire [2:0] pulse_gated = pulse_raw & pulse_gen_enable;
  assign pulse_gen_run = pulse_gen_enable;

  wire [2:0] next_pin_out;
  wire [2:0] next_pin_oe;

  genvar pin;
  for (pin = 0; pin < 3; pin = pin + 1) begin : g_pin
    wire [3:0] select =
      output_pin_config[pin*SOURCE_SELECT_WIDTH +: SOURCE_SELECT_WIDTH];
    wire open_drain = output_pin_config[OPEN_DRAIN_LSB + pin];
    logic level;
    logic driven;

    always_comb begin
      level  = 1'b0;
      driven = 1'b1;
      case (select)
        SRC_PULSE1:     level = pulse_gated[0];
        SRC_PULSE2:     level = pulse_gated[1];
        SRC_PULSE3:     level = pulse_gated[2];
        SRC_P1_SIGN:    level = power_sign[0];
        SRC_P2_SIGN:    level = power_sign[1];
        SRC_PSUM_SIGN:  level = power_sign[2];
        SRC_Q1_SIGN:    level = power_sign[3];
        SRC_Q2_SIGN:    level = power_sign[4];
        SRC_QSUM_SIGN:  level = power_sign[5];
        SRC_VOLTAGE_ZX: level = voltage_zero_cross;
        SRC_CURRENT_ZX: level = current_zero_cross;
        SRC_INTERRUPT:  level = interrupt_level;
        // Reserved codes float like the default, the safest choice
        default:        driven = 1'b0;
      endcase
    end

    assign next_pin_out[pin] = open_drain ? 1'b0 : level;
    assign next_pin_oe[pin]  = driven & (open_drain ? ~level : 1'b1);
  end

  // One process owns all pin bits, so no bit has two writers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= 3'h0;
      pin_oe  <= 3'h0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // Measurement engine options
  // ----------------------------------------------------------------
  wire positive_only = measurement_config[POSITIVE_ONLY_BIT];
  wire hold_choice   = measurement_config[HOLD_CHOICE_BIT];
  wire channel_bit   = measurement_config[CHANNEL_CHOICE_BIT];
  wire compare_rms   = measurement_config[COMPARE_RMS_BIT];
  wire [1:0] meter_configuration =
    measurement_config[METER_CONFIG_LSB +: 2];

  assign use_voltage_reference = measurement_config[FIXED_VOLTAGE_BIT];

  wire [POWER_WIDTH-1:0] next_p1_avg =
    (positive_only && p1_avg_raw[POWER_WIDTH-1]) ? '0 : p1_avg_raw;
  wire [POWER_WIDTH-1:0] next_p2_avg =
    (positive_only && p2_avg_raw[POWER_WIDTH-1]) ? '0 : p2_avg_raw;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p1_avg <= '0;
      p2_avg <= '0;
    end else begin
      p1_avg <= next_p1_avg;
      p2_avg <= next_p2_avg;
    end
  end

  wire channel1_wins =
    compare_rms ? channel1_current_larger : channel1_power_larger;
  wire pick_channel2 = hold_choice ? channel_bit : ~channel1_wins;
  assign total_half_sum      = meter_configuration == METER_HALF_SUM;
  assign total_from_channel2 =
    (meter_configuration == METER_ONE_CHANNEL) && pick_channel2;

  assign apparent_root_sum = measurement_config[APPARENT_METHOD_BIT];
  assign zero_cross_lowpass_en = measurement_config[ZX_LOWPASS_BIT];
  assign average_by_cycles = measurement_config[AVERAGING_BASIS_BIT];
  assign checksum_enable = ~measurement_config[CHECKSUM_DISABLE_BIT];
  assign integrator_gain_load =
    freq_measure_done & measurement_config[AUTO_FREQ_BIT];

  assign current1_filter_select =
    measurement_config[CURRENT1_FILTER_LSB +: 2];
  assign current2_filter_select =
    measurement_config[CURRENT2_FILTER_LSB +: 2];
  // Voltage filter fields, integrator code not offered; a written code 3 still passes through to both selects
  assign voltage1_filter_select =
    measurement_config[VOLTAGE1_FILTER_LSB +: 2];
  assign voltage2_filter_select =
    measurement_config[VOLTAGE2_FILTER_LSB +: 2];
  assign iir_in_path = ~measurement_config[IIR_BYPASS_BIT];

  // ----------------------------------------------------------------
  // Phase compensation
  // ----------------------------------------------------------------
  wire [1:0] coarse_phase_pair1 = phase_compensation[COARSE_PAIR1_LSB +: 2];
  wire [1:0] coarse_phase_pair2 = phase_compensation[COARSE_PAIR2_LSB +: 2];

  assign current1_delay = {1'b0, coarse_phase_pair1 == COARSE_CURRENT_1};
  assign current2_delay = {1'b0, coarse_phase_pair2 == COARSE_CURRENT_1};
  assign voltage1_delay =
    coarse_phase_pair1 == COARSE_VOLTAGE_2 ? 2'h2 :
    coarse_phase_pair1 == COARSE_VOLTAGE_1 ? 2'h1 : 2'h0;
  assign voltage2_delay =
    coarse_phase_pair2 == COARSE_VOLTAGE_2 ? 2'h2 :
    coarse_phase_pair2 == COARSE_VOLTAGE_1 ? 2'h1 : 2'h0;

  assign fine_phase_pair1 =
    phase_compensation[FINE_PAIR1_LSB +: FINE_PHASE_WIDTH];
  assign fine_phase_pair2 =
    phase_compensation[FINE_PAIR2_LSB +: FINE_PHASE_WIDTH];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pulse_gate_off: assert property (
    output_pin_config[3:0] == 4'h0 &&
    !output_pin_config[PULSE_GEN_ENABLE_LSB] |=> !pin_out[0])
    else $error("pin 1 pulsed while generator 1 disabled");

  a_open_drain_high: assert property (
    output_pin_config[OPEN_DRAIN_LSB] |=> !pin_out[0])
    else $error("open drain pin 1 drove high");

  a_route_pulse: assert property (
    output_pin_config[3:0] == 4'h1 && !output_pin_config[OPEN_DRAIN_LSB]
    |=> pin_oe[0] && pin_out[0] == $past(pulse_gated[1]))
    else $error("pin 1 did not carry pulse generator 2");

  a_route_sign: assert property (
    output_pin_config[7:4] == 4'h9 && !output_pin_config[OPEN_DRAIN_LSB+1]
    |=> pin_out[1] == $past(power_sign[5]))
    else $error("pin 2 did not carry summed reactive sign");

  a_route_zero_x: assert property (
    output_pin_config[11:8] == 4'hC && !output_pin_config[OPEN_DRAIN_LSB+2]
    |=> pin_out[2] == $past(current_zero_cross))
    else $error("pin 3 did not carry current zero-cross");

  a_route_voltage_x: assert property (
    output_pin_config[7:4] == 4'hB && !output_pin_config[OPEN_DRAIN_LSB+1]
    |=> pin_oe[1] && pin_out[1] == $past(voltage_zero_cross))
    else $error("pin 2 did not carry voltage zero-cross");

  a_route_interrupt: assert property (
    output_pin_config[11:8] == 4'hF && !output_pin_config[OPEN_DRAIN_LSB+2]
    |=> pin_oe[2] && pin_out[2] == $past(interrupt_level))
    else $error("pin 3 did not carry interrupt");

  a_high_z_idle: assert property (
    output_pin_config[3:0] == 4'hE |=> !pin_oe[0])
    else $error("pin 1 driven in high impedance mode");

  a_clamp_negative: assert property (
    positive_only && p1_avg_raw < 0 |=> p1_avg == 0)
    else $error("negative average kept in positive-only mode");

  a_half_sum: assert property (
    meter_configuration == 2'h1 |-> total_half_sum && !total_from_channel2)
    else $error("half sum mode not decoded");

  a_held_channel: assert property (
    meter_configuration == 2'h0 && hold_choice
    |-> total_from_channel2 == channel_bit)
    else $error("held channel ignored");

  a_auto_compare: assert property (
    meter_configuration == 2'h0 && !hold_choice && compare_rms
    |-> total_from_channel2 == !channel1_current_larger)
    else $error("automatic choice used wrong source");

  a_gain_update: assert property (
    integrator_gain_load |-> freq_measure_done && measurement_config[9])
    else $error("integrator gain loaded without measurement");

  a_coarse_delay: assert property (
    coarse_phase_pair1 == 2'h3 |-> voltage1_delay == 2'h2 &&
    current1_delay == 2'h0)
    else $error("coarse phase delay wrong");

  a_read_back: assert property (
    reg_write && hit_measurement ##1 hit_measurement && !reg_write
    |=> reg_read_data == $past(next_measurement_config, 2))
    else $error("read back mismatch");

  c_open_drain_pulse: cover property (
    output_pin_config[OPEN_DRAIN_LSB] && pulse_gated[0] ##1 pin_oe[0]);
  c_interrupt_route: cover property (
    output_pin_config[11:8] == 4'hF ##1 pin_oe[2]);
  c_half_sum: cover property (total_half_sum);
  c_gain_load: cover property (integrator_gain_load);

endmodule // meter_output_dsp_config
`default_nettype wire

// *** meter_output_dsp_config_bench.sv ***
// Self-checking bench for the meter configuration register bank
`timescale 1ns/1ns
`default_nettype none

module meter_output_dsp_config_bench;
  import meter_cfg_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic               clock;
  logic               rst;
  logic [5:0]         reg_address;
  logic               reg_write;
  logic [23:0]        reg_write_data;
  logic [23:0]        reg_read_data;
  logic [2:0]         pulse_raw;
  logic [5:0]         power_sign;
  logic               voltage_zero_cross, current_zero_cross;
  logic               interrupt_level, freq_measure_done;
  logic               channel1_power_larger, channel1_current_larger;
  logic signed [23:0] p1_avg_raw, p2_avg_raw, p1_avg, p2_avg;
  logic [2:0]         pulse_gen_run, pin_out, pin_oe;
  logic               use_voltage_reference, total_from_channel2;
  logic               total_half_sum, apparent_root_sum;
  logic               zero_cross_lowpass_en, average_by_cycles;
  logic               checksum_enable, integrator_gain_load, iir_in_path;
  logic [1:0]         current1_filter_select, current2_filter_select;
  logic [1:0]         voltage1_filter_select, voltage2_filter_select;
  logic [1:0]         current1_delay, voltage1_delay;
  logic [1:0]         current2_delay, voltage2_delay;
  logic [8:0]         fine_phase_pair1, fine_phase_pair2;
  logic [23:0]        m_meas, m_pin, m_phase;
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  meter_output_dsp_config #(.POWER_WIDTH(24)) dut_u (
    .clock, .rst, .reg_address, .reg_write, .reg_write_data,
    .reg_read_data, .pulse_raw, .power_sign, .voltage_zero_cross,
    .current_zero_cross, .interrupt_level, .channel1_power_larger,
    .channel1_current_larger, .freq_measure_done, .p1_avg_raw,
    .p2_avg_raw, .pulse_gen_run, .pin_out, .pin_oe, .p1_avg, .p2_avg,
    .use_voltage_reference, .total_from_channel2, .total_half_sum,
    .apparent_root_sum, .zero_cross_lowpass_en, .average_by_cycles,
    .checksum_enable, .integrator_gain_load, .current1_filter_select,
    .current2_filter_select, .voltage1_filter_select,
    .voltage2_filter_select, .iir_in_path, .current1_delay,
    .voltage1_delay, .current2_delay, .voltage2_delay,
    .fine_phase_pair1, .fine_phase_pair2
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_sim;
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [23:0] exp_rd(input logic [5:0] a);
    if (a == MEASUREMENT_CONFIG_IDX) return m_meas;
    if (a == OUTPUT_PIN_CONFIG_IDX) return m_pin;
    if (a == PHASE_COMPENSATION_IDX) return m_phase;
    return 24'h000000;
  endfunction

  // Current delay in the high pair of bits, voltage in the low pair
  function automatic logic [3:0] coarse(input logic [1:0] c);
    return {1'b0, c == 2'h1, c == 2'h3, c == 2'h2};
  endfunction

  // Leaves write high so that calls run back to back
  task automatic reg_wr(input logic [5:0] a, input logic [23:0] d);
    reg_address = a;
    reg_write = 1'b1;
    reg_write_data = d;
    @(negedge clock);
    if (a == MEASUREMENT_CONFIG_IDX) m_meas = d & MEASUREMENT_CONFIG_MASK;
    if (a == OUTPUT_PIN_CONFIG_IDX)
      m_pin = (d & OUTPUT_PIN_CONFIG_MASK) | OUTPUT_PIN_CONFIG_FIXED;
    if (a == PHASE_COMPENSATION_IDX) m_phase = d & PHASE_COMPENSATION_MASK;
  endtask

  task automatic reg_rd(input logic [5:0] a);
    reg_address = a;
    @(negedge clock);
    chk(reg_read_data, exp_rd(a), "read data");
  endtask

  task automatic drive;
    logic [31:0] r;
    r = $urandom;
    pulse_raw = r[2:0];
    power_sign = r[8:3];
    {voltage_zero_cross, current_zero_cross, interrupt_level} = r[11:9];
    {channel1_power_larger, channel1_current_larger} = r[13:12];
    freq_measure_done = (r[15:14] == 2'h0);
    r = $urandom;
    p1_avg_raw = r[23:0];
    p2_avg_raw = {r[7:0], r[31:16]};
  endtask

  // Inputs have been held over the edge just passed
  task automatic check_out;
    logic [3:0] code;
    logic       lvl, drv, od, t2;
    for (int i = 0; i < 3; i++) begin
      code = m_pin[4*i +: 4];
      od = m_pin[OPEN_DRAIN_LSB + i];
      drv = 1'b1;
      lvl = 1'b0;
      case (code)
        4'h0, 4'h1, 4'h2: lvl = pulse_raw[code] & m_pin[20 + code];
        4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: lvl = power_sign[code - 4'h4];
        4'hB: lvl = voltage_zero_cross;
        4'hC: lvl = current_zero_cross;
        4'hF: lvl = interrupt_level;
        default: drv = 1'b0;
      endcase
      chk(pin_oe[i], drv & ~(od & lvl), "pin enable");
      if (drv) chk(pin_out[i], lvl & ~od, "pin level");
    end
    chk(pulse_gen_run, m_pin[22:20], "pulse run"); // Enables
    chk(p1_avg, (m_meas[22] && p1_avg_raw[23]) ? 24'h0 : p1_avg_raw,
        "p1 average"); // Clamp
    chk(p2_avg, (m_meas[22] && p2_avg_raw[23]) ? 24'h0 : p2_avg_raw,
        "p2 average"); // Clamp
    chk({use_voltage_reference, apparent_root_sum, zero_cross_lowpass_en,
         average_by_cycles, checksum_enable, iir_in_path},
        {m_meas[23], m_meas[14], m_meas[12], m_meas[11], ~m_meas[10],
         ~m_meas[0]}, "mode bits");
    chk({current2_filter_select, voltage2_filter_select,
         current1_filter_select, voltage1_filter_select},
        m_meas[8:1], "filters"); // Filters
    chk(integrator_gain_load, freq_measure_done & m_meas[9],
        "gain load"); // Update
    t2 = m_meas[20] ? m_meas[21] : (m_meas[19] ? ~channel1_current_larger
                                               : ~channel1_power_larger);
    chk({total_half_sum, total_from_channel2},
        {m_meas[18:17] == 2'h1, (m_meas[18:17] == 2'h0) & t2},
        "totals"); // Totals
    chk({current1_delay, voltage1_delay, current2_delay, voltage2_delay},
        {coarse(m_phase[21:20]), coarse(m_phase[23:22])},
        "coarse"); // Delays
    chk({fine_phase_pair2, fine_phase_pair1}, m_phase[17:0],
        "fine"); // Steps
  endtask

  task automatic do_reset;
    rst = 1'b1;
    m_meas = MEASUREMENT_CONFIG_RESET;
    m_pin = OUTPUT_PIN_CONFIG_RESET;
    m_phase = PHASE_COMPENSATION_RESET;
    repeat (20) @(negedge clock);
    chk(pin_oe, 24'h0, "reset enable"); // Pins float
    chk(reg_read_data, 24'h0, "reset read");
    rst = 1'b0;
    reg_rd(MEASUREMENT_CONFIG_IDX);
    reg_rd(OUTPUT_PIN_CONFIG_IDX);
    reg_rd(PHASE_COMPENSATION_IDX);
    drive();
    @(negedge clock);
    check_out();
  endtask

  // ------------------------------------------------------------
  // Clock, timeout and sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Sequence needs about 880 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    logic [31:0] r;
    logic [23:0] d;
    logic [5:0]  ua;
    {reg_address, reg_write, reg_write_data} = '0;
    {pulse_raw, power_sign, voltage_zero_cross, current_zero_cross} = '0;
    {interrupt_level, freq_measure_done, channel1_power_larger} = '0;
    {channel1_current_larger, p1_avg_raw, p2_avg_raw} = '0;
    rst = 1'b1;
    r = $urandom(99);
    do_reset();
    // Every legal selector code reaches every pin
    for (int it = 0; it < 64; it++) begin
      r = $urandom;
      d = (r[23:0] & OUTPUT_PIN_CONFIG_MASK) | OUTPUT_PIN_CONFIG_FIXED;
      d[3:0] = it[3:0];
      d[7:4] = it[3:0] + 4'h5;
      d[11:8] = it[3:0] + 4'hA;
      for (int p = 0; p < 3; p++)
        if (d[4*p +: 4] == 4'h3 || d[4*p +: 4] == 4'hA ||
            d[4*p +: 4] == 4'hD) d[4*p +: 4] = 4'hE;
      ua = r[29:24];
      if (ua == 6'h00 || ua == 6'h01 || ua == 6'h05) ua = 6'h3F;
      reg_wr(OUTPUT_PIN_CONFIG_IDX, d);
      r = $urandom;
      reg_wr(PHASE_COMPENSATION_IDX, r[23:0] & PHASE_COMPENSATION_MASK);
      reg_wr(ua, ~r[23:0]);
      r = $urandom;
      d = r[23:0] & MEASUREMENT_CONFIG_MASK;
      // No reserved meter or voltage filter codes
      d[18] = 1'b0;
      if (d[2:1] == 2'h3) d[2] = 1'b0;
      if (d[6:5] == 2'h3) d[6] = 1'b0;
      // Last write then an idle read of it exercises the read-back path
      reg_wr(MEASUREMENT_CONFIG_IDX, d);
      reg_write = 1'b0;
      reg_rd(MEASUREMENT_CONFIG_IDX);
      reg_rd(OUTPUT_PIN_CONFIG_IDX);
      reg_rd(PHASE_COMPENSATION_IDX);
      reg_rd(ua);
      for (int k = 0; k < 5; k++) begin
        drive();
        @(negedge clock);
        check_out();
      end
    end
    // Second reset at the end of the run
    do_reset();
    end_sim();
  end
endmodule // meter_output_dsp_config_bench
`default_nettype wire
